// >>> dma_seq_pkg.sv
// Shared constants and types for the six channel DMA sequencer.
// Assumes a 16-bit register port and a 16-bit on-chip memory bus.
package dma_seq_pkg;

   typedef logic [15:0] word_t;

   // ----------------------------------------------------------------
   // Register port addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_PRIO    = 8'h54;
   localparam logic [7:0] ADDR_PTR     = 8'h55;
   localparam logic [7:0] ADDR_AUTOINC = 8'h56;
   localparam logic [7:0] ADDR_PLAIN   = 8'h57;

   // ----------------------------------------------------------------
   // Subbank map: pointer[5:3] channel, pointer[2:0] field
   // ----------------------------------------------------------------
   localparam logic [2:0] SB_SRC      = 3'h0;
   localparam logic [2:0] SB_DST      = 3'h1;
   localparam logic [2:0] SB_CNT      = 3'h2;
   localparam logic [2:0] SB_SYNC     = 3'h3;
   localparam logic [2:0] SB_MODE     = 3'h4;
   localparam logic [1:0] SB_GLOBAL   = 2'h3;
   localparam logic [2:0] G_SRC       = 3'h0;
   localparam logic [2:0] G_DST       = 3'h1;
   localparam logic [2:0] G_CNT       = 3'h2;
   localparam logic [2:0] G_FRM       = 3'h3;
   localparam logic [2:0] G_ESTEP0    = 3'h4;
   localparam logic [2:0] G_ESTEP1    = 3'h5;
   localparam logic [2:0] G_FSTEP0    = 3'h6;
   localparam logic [2:0] G_FSTEP1    = 3'h7;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PRIO_EN_LSB    = 0;
   localparam int PRIO_HI_LSB    = 8;
   localparam int PRIO_ROUTE_LSB = 14;
   localparam int MODE_AUTO      = 15;
   localparam int MODE_IEN       = 14;
   localparam int MODE_ITIM      = 13;
   localparam int MODE_ABU       = 12;
   localparam int MODE_DBL       = 11;
   localparam int MODE_SMODE_LSB = 9;
   localparam int MODE_SIDX      = 8;
   localparam int MODE_DMODE_LSB = 6;
   localparam int MODE_DIDX      = 5;
   localparam int SYNC_LSB       = 12;

   // ----------------------------------------------------------------
   // Reset values and codes
   // ----------------------------------------------------------------
   localparam word_t      RESET_WORD   = 16'h0000;
   localparam logic [1:0] ROUTE_SERIAL = 2'h0;
   localparam logic [1:0] ROUTE_UPPER  = 2'h1;
   localparam logic [1:0] ROUTE_ALL    = 2'h2;
   localparam logic [3:0] SYNC_NONE    = 4'h0;
   localparam logic [3:0] SYNC_S0_RX   = 4'h1;
   localparam logic [3:0] SYNC_S1_TX   = 4'h6;
   localparam logic [3:0] SYNC_TIMER   = 4'hd;
   localparam logic [3:0] SYNC_EXT3    = 4'he;

   typedef enum logic [1:0] {ADJ_HOLD, ADJ_INC, ADJ_DEC, ADJ_INDEX} adj_mode_t;
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_DONE} seq_state_t;

endpackage

// >>> arb_if.sv
// Request and grant signals between the sequencer and its arbiter.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface arb_if;
   logic [5:0] req;
   logic [5:0] high;
   logic       take;
   logic       valid;
   logic [2:0] grant;
   modport picker (input req, input high, input take,
                   output valid, output grant);
   modport user   (output req, output high, output take,
                   input valid, input grant);
endinterface

// >>> round_robin_pick.sv
// Two level rotating arbiter for six DMA channels.
// Assumes take is only raised while valid is high.
`timescale 1ns/1ps
module round_robin_pick
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Requests and grant
   arb_if.picker     arb
);
   logic [2:0] hi_ptr_ff;
   logic [2:0] lo_ptr_ff;
   logic [3:0] hi_pick;
   logic [3:0] lo_pick;

   // Search starts just after the last winner of that level
   function automatic logic [3:0] pick(input logic [5:0] m,
                                       input logic [2:0] last);
      logic [2:0] idx;
      pick = 4'h0;
      for (int i = 5; i >= 0; i--)
      begin
         idx = 3'((int'(last) + 1 + i) % 6);
         if (m[idx])
            pick = {1'b1, idx};
      end
   endfunction

   assign hi_pick   = pick(arb.req & arb.high, hi_ptr_ff);
   assign lo_pick   = pick(arb.req & ~arb.high, lo_ptr_ff);
   assign arb.valid = hi_pick[3] | lo_pick[3];
   assign arb.grant = hi_pick[3] ? hi_pick[2:0] : lo_pick[2:0];

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         hi_ptr_ff <= 3'h5;
         lo_ptr_ff <= 3'h5;
      end
      else if (arb.take && hi_pick[3])
         hi_ptr_ff <= hi_pick[2:0];
      else if (arb.take)
         lo_ptr_ff <= lo_pick[2:0];
   end
endmodule

// >>> six_channel_dma_sequencer.sv
// Six channel DMA sequencer: arbitration, address indexing, counting,
// autoinitialization, sync events and interrupt routing.
// Assumes a single-cycle memory bus with read data one cycle late.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module six_channel_dma_sequencer
   import dma_seq_pkg::*;
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          reset_n,
   // Register port
   input  wire logic [7:0]    reg_addr,
   input  wire dma_seq_pkg::word_t reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output      dma_seq_pkg::word_t reg_rdata,
   // Memory bus
   output      logic          mem_rd,
   output      logic          mem_wr,
   output      dma_seq_pkg::word_t mem_addr,
   output      dma_seq_pkg::word_t mem_wdata,
   input  wire dma_seq_pkg::word_t mem_rdata,
   output      logic          cpu_hold,
   // Sync events, one pulse line per select code
   input  wire logic [15:0]   sync_event_in,
   // Interrupts
   input  wire logic          serial2_rx_irq,
   input  wire logic          serial2_tx_irq,
   input  wire logic          serial1_rx_irq,
   input  wire logic          serial1_tx_irq,
   output      logic [3:0]    shared_irq,
   output      logic          channel4_irq,
   output      logic          channel5_irq
);
   import dma_seq_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   word_t      prio_ff;
   logic [5:0] ptr_ff;
   word_t      src_ff   [6];
   word_t      dst_ff   [6];
   word_t      ecnt_ff  [6];
   word_t      einit_ff [6];
   logic [7:0] frm_ff   [6];
   logic [3:0] sync_ff  [6];
   word_t      mode_ff  [6];
   word_t      gsrc_ff;
   word_t      gdst_ff;
   word_t      gcnt_ff;
   logic [7:0] gfrm_ff;
   word_t      estep_ff [2];
   word_t      fstep_ff [2];
   logic [5:0] pend_ff;
   logic [5:0] irq_pulse_ff;
   seq_state_t st_ff;
   logic [2:0] cur_ff;
   logic       half_ff;
   logic       final_ff;
   logic       blk_ff;
   word_t      rdata_ff;
   logic       mem_rd_ff;
   logic       mem_wr_ff;
   word_t      mem_addr_ff;
   word_t      mem_wdata_ff;
   logic       hold_ff;
   logic [3:0] shared_ff;
   logic       ch4_ff;
   logic       ch5_ff;

   arb_if arb ();

   round_robin_pick u_pick
   (
      .clk     (clk),
      .reset_n (reset_n),
      .arb     (arb.picker)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic word_t adjust(input word_t a, input adj_mode_t m,
                                    input word_t step);
      case (m)
         ADJ_HOLD:  adjust = a;
         ADJ_INC:   adjust = a + 16'h0001;
         ADJ_DEC:   adjust = a - 16'h0001;
         ADJ_INDEX: adjust = a + step;
         default:   adjust = a;
      endcase
   endfunction

   // Reserved codes never trigger, so a stray line cannot start a channel
   function automatic logic sync_code_ok(input logic [3:0] c);
      sync_code_ok = (c >= SYNC_S0_RX && c <= SYNC_S1_TX) ||
                     c == SYNC_TIMER || c == SYNC_EXT3;
   endfunction

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   wire        sel_prio = reg_addr == ADDR_PRIO;
   wire        sel_ptr  = reg_addr == ADDR_PTR;
   wire        sel_inc  = reg_addr == ADDR_AUTOINC;
   wire        sel_sb   = sel_inc || reg_addr == ADDR_PLAIN;
   wire        sb_glob  = ptr_ff[5:4] == SB_GLOBAL;
   wire [2:0]  sb_ch    = ptr_ff[5:3];
   wire [2:0]  sb_fld   = ptr_ff[2:0];
   wire        sb_ch_ok = !sb_glob && sb_ch < 3'h6;
   wire        sb_wr    = reg_wr && sel_sb;
   wire [1:0]  route    = prio_ff[PRIO_ROUTE_LSB +: 2];
   word_t      sb_word;

   always_comb
   begin
      sb_word = RESET_WORD;
      if (sb_glob)
         case (sb_fld)
            G_SRC:    sb_word = gsrc_ff;
            G_DST:    sb_word = gdst_ff;
            G_CNT:    sb_word = gcnt_ff;
            G_FRM:    sb_word = {8'h00, gfrm_ff};
            G_ESTEP0: sb_word = estep_ff[0];
            G_ESTEP1: sb_word = estep_ff[1];
            G_FSTEP0: sb_word = fstep_ff[0];
            default:  sb_word = fstep_ff[1];
         endcase
      else if (sb_ch_ok)
         case (sb_fld)
            SB_SRC:  sb_word = src_ff[sb_ch];
            SB_DST:  sb_word = dst_ff[sb_ch];
            SB_CNT:  sb_word = ecnt_ff[sb_ch];
            SB_SYNC: sb_word = {sync_ff[sb_ch], 4'h0, frm_ff[sb_ch]};
            SB_MODE: sb_word = mode_ff[sb_ch];
            default: sb_word = RESET_WORD;
         endcase
   end

   wire word_t rd_word = sel_prio ? prio_ff :
                         sel_ptr  ? {10'h000, ptr_ff} :
                         sel_sb   ? sb_word : RESET_WORD;

   // ----------------------------------------------------------------
   // Channel requests and the current transfer
   // ----------------------------------------------------------------
   logic [5:0] hit;
   logic [5:0] ready;

   always_comb
   begin
      for (int c = 0; c < 6; c++)
      begin
         hit[c]   = sync_code_ok(sync_ff[c]) &&
                    sync_event_in[sync_ff[c]];
         ready[c] = prio_ff[PRIO_EN_LSB + c] &&
                    (sync_ff[c] == SYNC_NONE || pend_ff[c]);
      end
   end

   assign arb.req  = ready;
   assign arb.high = prio_ff[PRIO_HI_LSB +: 6];
   assign arb.take = st_ff == ST_IDLE && arb.valid;

   wire word_t     cmode   = mode_ff[cur_ff];
   wire            dbl     = cmode[MODE_DBL];
   wire            autobuffering_mode     = cmode[MODE_ABU];
   wire            autoi   = cmode[MODE_AUTO];
   wire adj_mode_t smode   = adj_mode_t'(cmode[MODE_SMODE_LSB +: 2]);
   wire adj_mode_t dmode   = adj_mode_t'(cmode[MODE_DMODE_LSB +: 2]);
   wire            sidx    = cmode[MODE_SIDX];
   wire            didx    = cmode[MODE_DIDX];
   wire            elem_dn = !dbl || half_ff;
   wire            last_el = ecnt_ff[cur_ff] == RESET_WORD;
   wire            last_fr = frm_ff[cur_ff] == 8'h00;
   wire            fin     = elem_dn && last_el;
   wire word_t     ecnt_m1 = ecnt_ff[cur_ff] - 16'h0001;
   wire word_t     sstep   = fin ? fstep_ff[sidx] : estep_ff[sidx];
   wire word_t     dstep   = final_ff ? fstep_ff[didx]
                                      : estep_ff[didx];
   wire            blk_ev  = fin && last_fr;
   wire            frm_ev  = fin && !last_fr;
   wire            half_ev = elem_dn && !last_el && autobuffering_mode &&
                             ecnt_m1 == {1'b0, einit_ff[cur_ff][15:1]};
   wire            irq_ev  = cmode[MODE_IEN] &&
                             (blk_ev || (cmode[MODE_ITIM] &&
                              (autobuffering_mode ? half_ev : frm_ev)));

   // ----------------------------------------------------------------
   // Registers and sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         prio_ff  <= RESET_WORD;
         ptr_ff   <= 6'h00;
         gsrc_ff  <= RESET_WORD;
         gdst_ff  <= RESET_WORD;
         gcnt_ff  <= RESET_WORD;
         gfrm_ff  <= 8'h00;
         for (int c = 0; c < 6; c++)
         begin
            src_ff[c]   <= RESET_WORD;
            dst_ff[c]   <= RESET_WORD;
            ecnt_ff[c]  <= RESET_WORD;
            einit_ff[c] <= RESET_WORD;
            frm_ff[c]   <= 8'h00;
            sync_ff[c]  <= SYNC_NONE;
            mode_ff[c]  <= RESET_WORD;
         end
         for (int i = 0; i < 2; i++)
         begin
            estep_ff[i] <= RESET_WORD;
            fstep_ff[i] <= RESET_WORD;
         end
         pend_ff      <= 6'h00;
         irq_pulse_ff <= 6'h00;
         st_ff        <= ST_IDLE;
         cur_ff       <= 3'h0;
         half_ff      <= 1'b0;
         final_ff     <= 1'b0;
         blk_ff       <= 1'b0;
         mem_rd_ff    <= 1'b0;
         mem_wr_ff    <= 1'b0;
         mem_addr_ff  <= RESET_WORD;
         mem_wdata_ff <= RESET_WORD;
      end
      else
      begin
         // Software side; engine updates below win on a collision
         if (reg_wr && sel_prio)
            prio_ff <= reg_wdata;
         if (reg_wr && sel_ptr)
            ptr_ff <= reg_wdata[5:0];
         else if ((reg_wr || reg_rd) && sel_inc)
            ptr_ff <= ptr_ff + 6'h01;
         if (sb_wr && sb_glob)
            case (sb_fld)
               G_SRC:    gsrc_ff <= reg_wdata;
               G_DST:    gdst_ff <= reg_wdata;
               G_CNT:    gcnt_ff <= reg_wdata;
               G_FRM:    gfrm_ff <= reg_wdata[7:0];
               G_ESTEP0: estep_ff[0] <= reg_wdata;
               G_ESTEP1: estep_ff[1] <= reg_wdata;
               G_FSTEP0: fstep_ff[0] <= reg_wdata;
               default:  fstep_ff[1] <= reg_wdata;
            endcase
         else if (sb_wr && sb_ch_ok)
            case (sb_fld)
               SB_SRC:  src_ff[sb_ch] <= reg_wdata;
               SB_DST:  dst_ff[sb_ch] <= reg_wdata;
               SB_CNT:
               begin
                  ecnt_ff[sb_ch]  <= reg_wdata;
                  einit_ff[sb_ch] <= reg_wdata;
               end
               SB_SYNC:
               begin
                  sync_ff[sb_ch] <= reg_wdata[SYNC_LSB +: 4];
                  frm_ff[sb_ch]  <= reg_wdata[7:0];
               end
               SB_MODE: mode_ff[sb_ch] <= reg_wdata;
               default: mode_ff[sb_ch] <= mode_ff[sb_ch];
            endcase

         // A new event beats the clear of its own pending flag
         pend_ff <= (pend_ff & ~({5'h00, arb.take} << arb.grant)) |
                    hit;
         irq_pulse_ff <= 6'h00;

         case (st_ff)
            ST_IDLE:
               if (arb.valid)
               begin
                  cur_ff      <= arb.grant;
                  mem_rd_ff   <= 1'b1;
                  mem_addr_ff <= src_ff[arb.grant];
                  st_ff       <= ST_READ;
               end
            ST_READ:
            begin
               mem_rd_ff <= 1'b0;
               final_ff  <= fin;
               blk_ff    <= blk_ev;
               src_ff[cur_ff] <= adjust(src_ff[cur_ff], smode,
                                        sstep);
               irq_pulse_ff[cur_ff] <= irq_ev;
               if (elem_dn && !last_el)
                  ecnt_ff[cur_ff] <= ecnt_m1;
               else if (frm_ev)
               begin
                  frm_ff[cur_ff]  <= frm_ff[cur_ff] - 8'h01;
                  ecnt_ff[cur_ff] <= einit_ff[cur_ff];
               end
               else if (blk_ev && autoi)
               begin
                  src_ff[cur_ff]   <= gsrc_ff;
                  ecnt_ff[cur_ff]  <= gcnt_ff;
                  einit_ff[cur_ff] <= gcnt_ff;
                  frm_ff[cur_ff]   <= gfrm_ff;
               end
               else if (blk_ev && autobuffering_mode)
                  ecnt_ff[cur_ff] <= einit_ff[cur_ff];
               else if (blk_ev)
                  prio_ff[PRIO_EN_LSB + cur_ff] <= 1'b0;
               st_ff <= ST_WRITE;
            end
            ST_WRITE:
            begin
               mem_wr_ff    <= 1'b1;
               mem_addr_ff  <= dst_ff[cur_ff];
               mem_wdata_ff <= mem_rdata;
               st_ff        <= ST_DONE;
            end
            ST_DONE:
            begin
               mem_wr_ff <= 1'b0;
               if (blk_ff && autoi)
                  dst_ff[cur_ff] <= gdst_ff;
               else
                  dst_ff[cur_ff] <= adjust(dst_ff[cur_ff], dmode,
                                           dstep);
               if (dbl && !half_ff)
               begin
                  half_ff     <= 1'b1;
                  mem_rd_ff   <= 1'b1;
                  mem_addr_ff <= src_ff[cur_ff];
                  st_ff       <= ST_READ;
               end
               else
               begin
                  half_ff <= 1'b0;
                  st_ff   <= ST_IDLE;
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs: read data, bus hold and interrupt routing
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         rdata_ff  <= RESET_WORD;
         hold_ff   <= 1'b0;
         shared_ff <= 4'h0;
         ch4_ff    <= 1'b0;
         ch5_ff    <= 1'b0;
      end
      else
      begin
         rdata_ff <= reg_rd ? rd_word : RESET_WORD;
         hold_ff  <= st_ff != ST_IDLE || arb.valid;
         // Reserved route code falls back to the serial sources
         shared_ff[0] <= route == ROUTE_ALL ? irq_pulse_ff[0]
                                            : serial2_rx_irq;
         shared_ff[1] <= route == ROUTE_ALL ? irq_pulse_ff[1]
                                            : serial2_tx_irq;
         shared_ff[2] <= (route == ROUTE_ALL || route == ROUTE_UPPER) ?
                         irq_pulse_ff[2] : serial1_rx_irq;
         shared_ff[3] <= (route == ROUTE_ALL || route == ROUTE_UPPER) ?
                         irq_pulse_ff[3] : serial1_tx_irq;
         ch4_ff <= irq_pulse_ff[4];
         ch5_ff <= irq_pulse_ff[5];
      end
   end

   assign reg_rdata    = rdata_ff;
   assign mem_rd       = mem_rd_ff;
   assign mem_wr       = mem_wr_ff;
   assign mem_addr     = mem_addr_ff;
   assign mem_wdata    = mem_wdata_ff;
   assign cpu_hold     = hold_ff;
   assign shared_irq   = shared_ff;
   assign channel4_irq = ch4_ff;
   assign channel5_irq = ch5_ff;

endmodule

// >>> dma_mem_model.sv
// Behavioural on-chip memory seen by the DMA sequencer.
// Assumes read data is wanted only in the cycle after mem_rd.
`timescale 1ns/1ps
module dma_mem_model
   import dma_seq_pkg::*;
(
   // Clock
   input  wire logic               clk,
   // Memory bus
   input  wire logic               mem_rd,
   input  wire dma_seq_pkg::word_t mem_addr,
   output      dma_seq_pkg::word_t mem_rdata
);
   initial mem_rdata = 16'h0000;
   // Outside the valid cycle the data toggles, so a late sample shows up
   always @(posedge clk)
      mem_rdata <= mem_rd ? (mem_addr ^ 16'ha5a5) : ~mem_rdata;
endmodule

// >>> dma_seq_assertions.sv
// Port checker for the six channel DMA sequencer.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module dma_seq_assertions
(
   // Clock and reset
   input wire logic               clk,
   input wire logic               reset_n,
   // Watched ports
   input wire logic               reg_rd,
   input wire dma_seq_pkg::word_t reg_rdata,
   input wire logic               mem_rd,
   input wire logic               mem_wr,
   input wire dma_seq_pkg::word_t mem_wdata,
   input wire dma_seq_pkg::word_t mem_rdata,
   input wire logic               cpu_hold,
   input wire logic               channel4_irq,
   input wire logic               channel5_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------------------------------
   // Element move, bus hold, register read data and channel irq causes
   // ----------------------------------------------------------------
   sequence s_move;
      ##2 mem_wr ##0 (mem_wdata == $past(mem_rdata));
   endsequence
   a_read_then_write: assert property (mem_rd |-> s_move)
      else $error("read not followed by matching write");
   a_write_needs_read: assert property (mem_wr |-> $past(mem_rd, 2))
      else $error("write without earlier read");
   a_strobes_apart: assert property (!(mem_rd && mem_wr))
      else $error("read and write strobes together");
   a_read_spacing: assert property (mem_rd |=> !mem_rd [*2])
      else $error("reads too close together");
   a_hold_on_bus: assert property ((mem_rd || mem_wr) |-> cpu_hold)
      else $error("bus used without cpu hold");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   a_ch4_irq_cause: assert property (channel4_irq |-> $past(mem_rd, 2))
      else $error("channel 4 irq without read");
   a_ch5_irq_cause: assert property (channel5_irq |-> $past(mem_rd, 2))
      else $error("channel 5 irq without read");
endmodule
bind six_channel_dma_sequencer dma_seq_assertions u_chk
(
   .clk(clk), .reset_n(reset_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
   .mem_rdata(mem_rdata), .cpu_hold(cpu_hold),
   .channel4_irq(channel4_irq), .channel5_irq(channel5_irq)
);

// >>> six_channel_dma_sequencer_test.sv
// Self-checking bench for the six channel DMA sequencer.
// Assumes the memory model answers every read in the next cycle.
`timescale 1ns/1ps
module six_channel_dma_sequencer_test;
   import dma_seq_pkg::*;
   logic        clk, reset_n, reg_wr, reg_rd, mem_rd, mem_wr, cpu_hold;
   logic        s2r, s1t, c4, c5, irq0;
   logic [1:0]  irq45;
   logic [7:0]  reg_addr;
   logic [15:0] sync_event_in;
   logic [3:0]  shared_irq;
   word_t       reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata;
   word_t       rq[$], wq[$], dq[$];
   int          n_fail, tests_run, cycles;

   six_channel_dma_sequencer dut (.clk(clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .cpu_hold(cpu_hold),
      .sync_event_in(sync_event_in), .serial2_rx_irq(s2r),
      .serial2_tx_irq(1'b0), .serial1_rx_irq(1'b0), .serial1_tx_irq(s1t),
      .shared_irq(shared_irq), .channel4_irq(c4), .channel5_irq(c5));
   dma_mem_model mem (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // Bus monitor and timeout
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      if (mem_rd) rq.push_back(mem_addr);
      if (mem_wr) wq.push_back(mem_addr);
      if (mem_wr) dq.push_back(mem_wdata);
      if (shared_irq[0] === 1'b1) irq0 <= 1'b1;
      if (c4 === 1'b1) irq45[0] <= 1'b1;
      if (c5 === 1'b1) irq45[1] <= 1'b1;
      cycles++;
      // Whole run needs well under a thousand cycles
      if (cycles == 5000)
      begin
         n_fail++;
         print_verdict;
      end
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task print_verdict;
      if (n_fail == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   task wr(input logic [7:0] a, input word_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output word_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_reset_route;
      word_t d;
      rd(ADDR_PRIO, d);
      chk(d === 16'h0000, "priority word not clear");
      @(posedge clk);
      s2r <= 1'b1;
      s1t <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(shared_irq === 4'h9, "serial lines misrouted");
      @(posedge clk);
      s2r <= 1'b0;
      s1t <= 1'b0;
   endtask
   task t_subbank;
      word_t d;
      wr(ADDR_PTR, 16'h0000);
      wr(ADDR_AUTOINC, 16'h0100);
      wr(ADDR_AUTOINC, 16'h0200);
      wr(ADDR_AUTOINC, 16'h0001);
      wr(ADDR_AUTOINC, 16'h0000);
      // Both pointers increment, irq enabled, block irq timing
      wr(ADDR_AUTOINC, 16'h4240);
      rd(ADDR_PTR, d);
      chk(d === 16'h0005, "pointer not advanced");
      rd(ADDR_PLAIN, d);
      chk(d === 16'h0000, "unused field not zero");
      rd(ADDR_PTR, d);
      chk(d === 16'h0005, "plain port moved pointer");
   endtask
   task t_move;
      // The serial source already pulsed line 0 during the route test
      irq0 = 1'b0;
      wr(ADDR_PRIO, 16'h8001);
      repeat (30) @(posedge clk);
      #1 chk(wq.size() == 2, "element count wrong");
      chk(wq[0] === 16'h0200 && wq[1] === 16'h0201, "dst step");
      chk(dq[1] === (16'h0101 ^ 16'ha5a5), "data moved wrong");
      chk(irq0 === 1'b1, "no block irq on line 0");
      rq.delete();
   endtask
   task t_index;
      word_t d;
      int    i;
      wr(ADDR_PTR, 16'h0034);
      wr(ADDR_AUTOINC, 16'h0003);
      wr(ADDR_AUTOINC, 16'h0000);
      wr(ADDR_AUTOINC, 16'h000a);
      wr(ADDR_PTR, 16'h0008);
      wr(ADDR_AUTOINC, 16'h0010);
      wr(ADDR_AUTOINC, 16'h0300);
      wr(ADDR_AUTOINC, 16'h0002);
      wr(ADDR_AUTOINC, 16'hd000);
      wr(ADDR_AUTOINC, 16'h0640);
      wr(ADDR_PRIO, 16'h8002);
      repeat (8) @(posedge clk);
      #1 chk(rq.size() == 0, "moved without event");
      for (i = 0; i < 3; i++)
      begin
         @(posedge clk);
         sync_event_in <= 16'h2000;
         @(posedge clk);
         sync_event_in <= 16'h0000;
         repeat (8) @(posedge clk);
         #1 chk(rq.size() == i + 1, "one element per event");
         chk(rq[i] === 16'h0010 + 16'(3 * i), "element step");
      end
      wr(ADDR_PTR, 16'h0008);
      rd(ADDR_PLAIN, d);
      chk(d === 16'h0020, "frame step not used");
   endtask
   // Channels 4 and 5 share the low level; channel 5 moves word pairs
   task t_rr;
      rq.delete();
      for (int c = 4; c < 6; c++)
      begin
         wr(ADDR_PTR, 16'(8 * c));
         wr(ADDR_AUTOINC, 16'(256 * c));
         wr(ADDR_AUTOINC, 16'h0f00);
         wr(ADDR_AUTOINC, 16'h0001);
         wr(ADDR_AUTOINC, 16'h0000);
         wr(ADDR_AUTOINC, 16'h4240 | (16'(c - 4) << 11));
      end
      wr(ADDR_PRIO, 16'h0030);
      repeat (40) @(posedge clk);
      #1 chk(rq.size() == 6, "pair counted as one element");
      chk(rq[0] === 16'h0400 && rq[1] === 16'h0500, "rr start");
      chk(rq[3] === 16'h0401 && rq[4] === 16'h0502, "rr rotation");
      chk(rq[2] === 16'h0501 && rq[5] === 16'h0503, "pair halves");
      chk(irq45 === 2'b11, "channel 4 or 5 irq missing");
   endtask

   initial
   begin
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      sync_event_in = 16'h0000;
      s2r = 1'b0;
      s1t = 1'b0;
      irq0 = 1'b0;
      irq45 = 2'b00;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      t_reset_route;
      t_subbank;
      t_move;
      t_index;
      t_rr;
      print_verdict;
   end
endmodule
